// *** cet_consts.vh ***
// Constants for the operand execution pipeline timing block
// Function
// - Non multi-register stores mark store resources busy two cycles, stalling later stores; a later multi-register store does not wait.
// - Word aligned on 0 modulo 2, long on 0 modulo 4, else misaligned.
// - Split misaligned: odd word byte,byte; odd long byte,word,byte; long at 10 word,word. The code splits only the read when there is one.
// - PC-relative modes take the same cycles as matching address-register modes.
// - Byte/word moves take 1, 2, 4 or 5 cycles by addressing mode.
// - Long moves match for register/immediate; memory source 3, indexed 4 cycles.
// - MAC moves: load accumulator/mask 1, status 2, reads 3 cycles when idle.
// - Read-modify-write memory operand issues one read and one write.
// - Cycle count includes operand accesses and internal cycles, zero-wait memory assumed.
`ifndef CET_CONSTS_VH
`define CET_CONSTS_VH
// Addressing mode codes
`define CET_EA_DREG      4'h0
`define CET_EA_AREG      4'h1
`define CET_EA_IND       4'h2
`define CET_EA_POSTINC   4'h3
`define CET_EA_PREDEC    4'h4
`define CET_EA_DISP      4'h5
`define CET_EA_INDEX     4'h6
`define CET_EA_ABSW      4'h7
`define CET_EA_ABSL      4'h8
`define CET_EA_PCDISP    4'h9
`define CET_EA_PCINDEX   4'hA
`define CET_EA_IMM       4'hB
// Operation codes
`define CET_OP_MOVE      3'h0
`define CET_OP_LOAD_ACCUM  3'h1
`define CET_OP_LOAD_STATUS 3'h2
`define CET_OP_LOAD_MASK   3'h3
`define CET_OP_FROM_MAC  3'h4
`define CET_OP_RMW       3'h5
// Operand size codes
`define CET_SZ_BYTE      2'h0
`define CET_SZ_WORD      2'h1
`define CET_SZ_LONG      2'h2
// Timing counts in cycles
`define CET_STORE_BUSY   2'h2
`define CET_T_REG        4'h1
`define CET_T_IDX_DST    4'h2
`define CET_T_MEM_BW     4'h4
`define CET_T_MEM_IDX_BW 4'h5
`define CET_T_MEM_L      4'h3
`define CET_T_MEM_IDX_L  4'h4
`define CET_T_MAC_STATUS 4'h2
`define CET_T_MAC_READ   4'h3
// Added cycles for a split operand: odd word, odd long, long at half-word
`define CET_T_MIS_WO_RD  4'h2
`define CET_T_MIS_WO_WR  4'h1
`define CET_T_MIS_LO_RD  4'h3
`define CET_T_MIS_LO_WR  4'h2
`define CET_T_MIS_LH_RD  4'h2
`define CET_T_MIS_LH_WR  4'h1
`endif

// *** cet_core_timing.v ***
// Operand execution pipeline cycle-timing sequencer
`timescale 1ns/100ps
`include "cet_consts.vh"
module cet_core_timing (
    input  wire        clock,
    input  wire        rst,
    input  wire        issue_valid,
    input  wire [2:0]  issue_op,
    input  wire [1:0]  issue_size,
    input  wire [3:0]  issue_src,
    input  wire [3:0]  issue_dst,
    input  wire [1:0]  issue_addr_lo,
    input  wire        issue_multi_reg,
    input  wire        mac_pipe_busy,
    output reg         issue_ready,
    output reg         stall,
    output reg         misaligned,
    output reg         done,
    output reg  [5:0]  done_cycles,
    output reg  [1:0]  done_reads,
    output reg  [1:0]  done_writes,
    output reg  [1:0]  busy_count
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_EXEC = 2'd2;

    reg [1:0] state_reg;
    reg [5:0] left_reg;
    reg [5:0] total_reg;
    reg [1:0] rd_reg;
    reg [1:0] wr_reg;
    reg       store_reg;
    reg       multi_reg;
    reg [2:0] op_reg;
    reg [1:0] size_reg;
    reg [3:0] src_reg;
    reg [3:0] dst_reg;
    reg [1:0] alo_reg;

    function is_mem;
        input [3:0] ea;
        begin
            is_mem = (ea != `CET_EA_DREG) && (ea != `CET_EA_AREG) && (ea != `CET_EA_IMM);
        end
    endfunction

    // PC-relative forms fold onto the address-register forms
    function is_index;
        input [3:0] ea;
        begin
            is_index = (ea == `CET_EA_INDEX) || (ea == `CET_EA_PCINDEX);
        end
    endfunction

    // Added cycles for a split operand, separately for a read and for a write
    function [3:0] mis_extra;
        input [1:0] sz;
        input [1:0] alo;
        input       wr;
        begin
            mis_extra = 4'h0;
            if (sz == `CET_SZ_WORD && alo[0])
                mis_extra = wr ? `CET_T_MIS_WO_WR : `CET_T_MIS_WO_RD;
            else if (sz == `CET_SZ_LONG && alo[0])
                mis_extra = wr ? `CET_T_MIS_LO_WR : `CET_T_MIS_LO_RD;
            else if (sz == `CET_SZ_LONG && alo == 2'b10)
                mis_extra = wr ? `CET_T_MIS_LH_WR : `CET_T_MIS_LH_RD;
        end
    endfunction

    function is_mis;
        input [1:0] sz;
        input [1:0] alo;
        begin
            is_mis = (sz == `CET_SZ_WORD && alo[0]) ||
                     (sz == `CET_SZ_LONG && alo != 2'b00);
        end
    endfunction

    // Aligned accesses added by a split: two for an odd long, one otherwise
    function [1:0] mis_accs;
        input [1:0] sz;
        input [1:0] alo;
        begin
            mis_accs = (sz == `CET_SZ_LONG && alo[0]) ? 2'h2 : 2'h1;
        end
    endfunction

    // Base cycles, reads and writes for the latched instruction
    reg [3:0] base_c;
    reg       base_r;
    reg       base_w;
    reg       src_m;
    reg       dst_m;
    always @* begin
        src_m  = is_mem(src_reg);
        dst_m  = is_mem(dst_reg);
        base_c = `CET_T_REG;
        base_r = 1'b0;
        base_w = 1'b0;
        case (op_reg)
            `CET_OP_MOVE: begin
                base_r = src_m;
                base_w = dst_m;
                if (src_m) begin
                    if (size_reg == `CET_SZ_LONG)
                        base_c = (is_index(src_reg) || is_index(dst_reg)) ?
                                 `CET_T_MEM_IDX_L : `CET_T_MEM_L;
                    else
                        base_c = (is_index(src_reg) || is_index(dst_reg)) ?
                                 `CET_T_MEM_IDX_BW : `CET_T_MEM_BW;
                end else if (is_index(dst_reg) ||
                             (src_reg == `CET_EA_IMM && dst_m))
                    base_c = `CET_T_IDX_DST;
            end
            `CET_OP_LOAD_ACCUM:  base_c = `CET_T_REG;
            `CET_OP_LOAD_MASK:   base_c = `CET_T_REG;
            `CET_OP_LOAD_STATUS: base_c = `CET_T_MAC_STATUS;
            `CET_OP_FROM_MAC: base_c = `CET_T_MAC_READ;
            `CET_OP_RMW: begin
                base_r = 1'b1;
                base_w = 1'b1;
                base_c = is_index(dst_reg) ? `CET_T_MEM_IDX_BW : `CET_T_MEM_BW;
            end
            default: base_c = `CET_T_REG;
        endcase
    end

    // Misalignment splits the memory read when there is one, otherwise the memory write
    wire       mis_rd  = base_r && is_mis(size_reg, alo_reg);
    wire       mis_wr  = !base_r && base_w && is_mis(size_reg, alo_reg);
    wire [3:0] add_rd  = mis_rd ? mis_extra(size_reg, alo_reg, 1'b0) : 4'h0;
    wire [3:0] add_wr  = mis_wr ? mis_extra(size_reg, alo_reg, 1'b1) : 4'h0;
    wire [1:0] x_ops_r = mis_rd ? mis_accs(size_reg, alo_reg) : 2'h0;
    wire [1:0] x_ops_w = mis_wr ? mis_accs(size_reg, alo_reg) : 2'h0;
    wire [5:0] total_c = {2'b00, base_c} + {2'b00, add_rd} + {2'b00, add_wr};
    wire       is_store = base_w;

    // Store hazard: a new non multi-register store waits while shared store resources are busy
    // The take edge already counts the window down, so a store waits at most one cycle
    wire hazard = is_store && !multi_reg && (busy_count != 2'd0);
    // A read of the multiply-accumulate registers waits until that pipeline drains
    wire mac_hold = (op_reg == `CET_OP_FROM_MAC) && mac_pipe_busy;

    reg [1:0] state_next;
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (issue_valid) state_next = ST_WAIT;
            ST_WAIT: if (!hazard && !mac_hold) state_next = ST_EXEC;
            ST_EXEC: if (left_reg == 6'd1) state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            left_reg    <= 6'd0;
            total_reg   <= 6'd0;
            rd_reg      <= 2'd0;
            wr_reg      <= 2'd0;
            store_reg   <= 1'b0;
            multi_reg   <= 1'b0;
            op_reg      <= `CET_OP_MOVE;
            size_reg    <= `CET_SZ_BYTE;
            src_reg     <= `CET_EA_DREG;
            dst_reg     <= `CET_EA_DREG;
            alo_reg     <= 2'b00;
            busy_count  <= 2'd0;
            issue_ready <= 1'b1;
            stall       <= 1'b0;
            misaligned  <= 1'b0;
            done        <= 1'b0;
            done_cycles <= 6'd0;
            done_reads  <= 2'd0;
            done_writes <= 2'd0;
        end else begin
            state_reg <= state_next;
            done      <= 1'b0;
            if (busy_count != 2'd0)
                busy_count <= busy_count - 2'd1;
            case (state_reg)
                ST_IDLE: if (issue_valid) begin
                    op_reg      <= issue_op;
                    size_reg    <= issue_size;
                    src_reg     <= issue_src;
                    dst_reg     <= issue_dst;
                    alo_reg     <= issue_addr_lo;
                    multi_reg   <= issue_multi_reg;
                    issue_ready <= 1'b0;
                end
                ST_WAIT: begin
                    stall <= hazard || mac_hold;
                    if (!hazard && !mac_hold) begin
                        left_reg   <= total_c;
                        total_reg  <= total_c;
                        rd_reg     <= {1'b0, base_r} + x_ops_r;
                        wr_reg     <= {1'b0, base_w} + x_ops_w;
                        store_reg  <= is_store && !multi_reg;
                        misaligned <= mis_rd || mis_wr;
                    end
                end
                ST_EXEC: begin
                    left_reg <= left_reg - 6'd1;
                    if (left_reg == 6'd1) begin
                        done        <= 1'b1;
                        done_cycles <= total_reg;
                        done_reads  <= rd_reg;
                        done_writes <= wr_reg;
                        issue_ready <= 1'b1;
                        // Busy window opens after the final data cycle
                        if (store_reg)
                            busy_count <= `CET_STORE_BUSY;
                    end
                end
                default: issue_ready <= 1'b1;
            endcase
        end
    end
endmodule // cet_core_timing

// *** cet_timing_checker.sv ***
// Assertion checker for the operand timing sequencer
`timescale 1ns/100ps
module cet_timing_checker (
    input wire       clock,
    input wire       rst,
    input wire       issue_valid,
    input wire [2:0] issue_op,
    input wire [3:0] issue_src,
    input wire [3:0] issue_dst,
    input wire       mac_pipe_busy,
    input wire       issue_ready,
    input wire       stall,
    input wire       done,
    input wire [5:0] done_cycles,
    input wire [1:0] busy_count
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence take_s;
        issue_valid && issue_ready;
    endsequence
    sequence reg_move_s;
        take_s ##0 (issue_op == 3'h0 && issue_src == 4'h0 && issue_dst == 4'h0);
    endsequence
    sequence window_s;
        busy_count == 2'h1 ##1 busy_count == 2'h0;
    endsequence
    chk_take_drops: assert property (take_s |=> !issue_ready)
        else $error("ready stayed high after a take");
    chk_reg_move: assert property (
        reg_move_s |-> ##[2:3] (done && done_cycles == 6'h01)) else $error("slow register move");
    chk_done_pulse: assert property (done |=> !done)
        else $error("done longer than one cycle");
    chk_ready_rise: assert property ($rose(issue_ready) |-> done)
        else $error("ready rose without done");
    chk_busy_window: assert property (busy_count == 2'h2 |=> window_s)
        else $error("store window not two cycles");
    chk_busy_start: assert property (busy_count == 2'h2 |-> done)
        else $error("store window opened without done");
    chk_stall_cause: assert property (stall |-> (busy_count != 2'h0 ||
        $past(busy_count) != 2'h0 || mac_pipe_busy || $past(mac_pipe_busy)))
        else $error("stall without cause");
    chk_reset_clear: assert property ($fell(rst) |-> (issue_ready && busy_count == 2'h0))
        else $error("reset left the sequencer busy");
endmodule // cet_timing_checker
bind cet_core_timing cet_timing_checker cet_timing_checker_inst (
    .clock         (clock),
    .rst           (rst),
    .issue_valid   (issue_valid),
    .issue_op      (issue_op),
    .issue_src     (issue_src),
    .issue_dst     (issue_dst),
    .mac_pipe_busy (mac_pipe_busy),
    .issue_ready   (issue_ready),
    .stall         (stall),
    .done          (done),
    .done_cycles   (done_cycles),
    .busy_count    (busy_count)
);

// *** cet_tb.sv ***
// Self-checking bench for the operand timing sequencer
`timescale 1ns/100ps
`define CHK(nm, g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
    reg        clock = 1'b0;
    reg        rst = 1'b1;
    reg        issue_valid = 1'b0;
    reg        issue_multi_reg = 1'b0;
    reg        mac_pipe_busy = 1'b0;
    reg  [2:0] issue_op = 3'h0;
    reg  [1:0] issue_size = 2'h0;
    reg  [1:0] issue_addr_lo = 2'h0;
    reg  [3:0] issue_src = 4'h0;
    reg  [3:0] issue_dst = 4'h0;
    wire       issue_ready, stall, misaligned, done;
    wire [5:0] done_cycles;
    wire [1:0] done_reads, done_writes, busy_count;
    int        err_total = 0;
    int        compares = 0;
    localparam int LAUNCH = 3;
    int        stl;
    cet_core_timing cet_core_timing_inst (
        .clock           (clock),
        .rst             (rst),
        .issue_valid     (issue_valid),
        .issue_op        (issue_op),
        .issue_size      (issue_size),
        .issue_src       (issue_src),
        .issue_dst       (issue_dst),
        .issue_addr_lo   (issue_addr_lo),
        .issue_multi_reg (issue_multi_reg),
        .mac_pipe_busy   (mac_pipe_busy),
        .issue_ready     (issue_ready),
        .stall           (stall),
        .misaligned      (misaligned),
        .done            (done),
        .done_cycles     (done_cycles),
        .done_reads      (done_reads),
        .done_writes     (done_writes),
        .busy_count      (busy_count)
    );
    always #2.5 clock = ~clock;
    task automatic finish_test;
        $display("Mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // op bit 3 = multi-register; f = {src, dst, size, addr_lo}
    // x = {cycles:8, reads:4, misaligned, 1'b0, writes:2}; cnt back-to-back copies
    task automatic go(input [3:0] op, input [11:0] f, input [15:0] x, input int cnt);
        int n = 0;
        int k = 0;
        int tk = 0;
        repeat (4) @(posedge clock);
        {issue_multi_reg, issue_op} <= op;
        {issue_src, issue_dst, issue_size, issue_addr_lo} <= f;
        issue_valid <= 1'b1;
        stl = 0;
        while (k < cnt && n < 80) begin
            @(posedge clock);
            n++;
            if (issue_ready === 1'b1) tk++;
            if (tk >= cnt) issue_valid <= 1'b0;
            if (done === 1'b1) k++;
            if (stall === 1'b1) stl++;
        end
        // Take edge, wait cycle and the edge that samples done come on top of C
        `CHK("completions", k, cnt)
        `CHK("cycles", done_cycles, x[13:8])
        `CHK("reads", done_reads, x[5:4])
        `CHK("writes", done_writes, x[1:0])
        `CHK("misaligned", misaligned, x[3])
        if (cnt == 1) `CHK("latency", n - stl, int'(x[13:8]) + LAUNCH)
    endtask
    task automatic t_moves;
        go(4'h0, 12'h000, 16'h0100, 1);
        go(4'h0, 12'h124, 16'h0101, 1);
        go(4'h0, 12'h060, 16'h0201, 1);
        go(4'h0, 12'hB34, 16'h0201, 1);
        go(4'h0, 12'h200, 16'h0410, 1);
        go(4'h0, 12'h644, 16'h0511, 1);
        go(4'h0, 12'h710, 16'h0410, 1);
        go(4'h0, 12'h900, 16'h0410, 1);
        go(4'h0, 12'hA34, 16'h0511, 1);
        go(4'h0, 12'h588, 16'h0311, 1);
        go(4'h0, 12'h368, 16'h0411, 1);
        go(4'h0, 12'hB28, 16'h0201, 1);
    endtask
    task automatic t_misalign;
        go(4'h0, 12'h206, 16'h0410, 1);
        go(4'h0, 12'h203, 16'h0410, 1);
        go(4'h0, 12'h205, 16'h0628, 1);
        go(4'h0, 12'h209, 16'h0638, 1);
        go(4'h0, 12'h20A, 16'h0528, 1);
        go(4'h0, 12'h027, 16'h020A, 1);
        go(4'h0, 12'h029, 16'h030B, 1);
    endtask
    task automatic t_mac_rmw;
        go(4'h1, 12'hB08, 16'h0100, 1);
        go(4'h2, 12'h008, 16'h0200, 1);
        go(4'h3, 12'h008, 16'h0100, 1);
        go(4'h4, 12'h008, 16'h0300, 1);
        mac_pipe_busy <= 1'b1;
        fork
            go(4'h4, 12'h008, 16'h0300, 1);
            begin
                repeat (9) @(posedge clock);
                mac_pipe_busy <= 1'b0;
            end
        join
        `CHK("mac wait", stl > 0, 1'b1)
        go(4'h5, 12'h028, 16'h0411, 1);
        go(4'h5, 12'h068, 16'h0511, 1);
    endtask
    task automatic t_store_hazard;
        go(4'h0, 12'h028, 16'h0101, 2);
        `CHK("store stall", stl inside {[1:2]}, 1'b1)
        go(4'h8, 12'h028, 16'h0101, 2);
        `CHK("multi stall", stl, 0)
    endtask
    task automatic t_reset;
        go(4'h0, 12'h028, 16'h0101, 1);
        `CHK("window open", busy_count !== 2'h0, 1'b1)
        // Reset lands on the edge after a one-cycle store, while its window is open
        repeat (4) @(posedge clock);
        issue_valid <= 1'b1;
        @(posedge clock);
        issue_valid <= 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        `CHK("done before reset", done, 1'b1)
        rst <= 1'b0;
        @(posedge clock);
        `CHK("busy after reset", busy_count, 2'h0)
        `CHK("ready after reset", issue_ready, 1'b1)
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_moves();
        t_misalign();
        t_mac_rmw();
        t_store_hazard();
        t_reset();
        finish_test();
    end
    // Far beyond the few hundred cycles the scenarios need
    initial begin
        #40000;
        err_total++;
        finish_test();
    end
endmodule // tb
